/* File: rtl/splp_top.sv */
// Purpose: Latches hub straps and runs the shared port power/over-current pins.
// Assumes: reset_n is the combined power-on and external chip reset.
// Notes: Config register reached through a simple write/read port.
//
// Notes on behaviour
// - Port 1 pin drives power, senses over-current.
// - Port 2 pin drives power, senses over-current.
// - Port 1 strap high enables charging.
// - Port 2 strap high enables charging.
// - Port 2 power high enables power.
// - Port 1 power high enables power.
// - Sample self-power detect after reset release.
// - Hold self-power value unless dynamic switching.
// - Self-power use ignores fixed-device straps.
// - Capture all straps at each reset release.
`timescale 1ns/1ps
`default_nettype none
module splp_top (
  input wire logic mclk,
  input wire logic reset_n,
  // Shared pin of port 1: input level, output value, output enable.
  input wire logic port1_ctl_in,
  output logic port1_ctl_out,
  output logic port1_ctl_oe,
  // Shared pin of port 2.
  input wire logic port2_ctl_in,
  output logic port2_ctl_out,
  output logic port2_ctl_oe,
  // Combined control selects, set by configuration.
  input wire logic port1_combined_control,
  input wire logic port2_combined_control,
  // Dedicated over-current inputs, active low.
  input wire logic port1_overcurrent_low,
  input wire logic port2_overcurrent_low,
  // Self-power detect pin and fixed-device strap pins.
  input wire logic self_power_detect,
  input wire logic [1:0] fixed_device_straps,
  // Fixed-device state written by the configuring party.
  input wire logic [1:0] fixed_device_cfg,
  // Power requests from the hub core.
  input wire logic port1_power_req,
  input wire logic port2_power_req,
  // Register port.
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Results.
  output logic port1_charging_en,
  output logic port2_charging_en,
  output logic self_powered,
  output logic [1:0] fixed_device,
  output logic port1_overcurrent,
  output logic port2_overcurrent,
  output logic config_done
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Synchronised pin levels: p1 pin, p2 pin, oc1, oc2, self-power, straps.
  logic [6:0] pins_s;
  splp_sync #(.W(7), .INIT(7'h7f)) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .async_in({fixed_device_straps, self_power_detect, port2_overcurrent_low,
               port1_overcurrent_low, port2_ctl_in, port1_ctl_in}),
    .sync_out(pins_s)
  );

  // ----------------------------------------------------------------
  // Configuration sequencing and strap capture
  // ----------------------------------------------------------------
  // State and counter.
  splp_pkg::splp_state_t state_q, state_d;
  logic [splp_pkg::CFG_CNT_W-1:0] cnt_q, cnt_d;
  // Captured straps.
  logic bc1_q, bc1_d, bc2_q, bc2_d, lp_q, lp_d;
  logic [1:0] fd_q, fd_d;
  // Dynamic power register.
  logic [7:0] dyn_q, dyn_d;
  // Dynamic switching enabled.
  logic dyn_en;

  assign dyn_en = (dyn_q == splp_pkg::DYN_PWR_ENABLE);

  // Next-state for sequencing, straps and register.
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    bc1_d = bc1_q;
    bc2_d = bc2_q;
    lp_d = lp_q;
    fd_d = fd_q;
    dyn_d = dyn_q;
    case (state_q)
      // Wait for synchronisers to settle after reset release.
      splp_pkg::SPLP_WAIT:
      begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == splp_pkg::CFG_CNT_W'(splp_pkg::CFG_CYCLES - 1))
        begin
          state_d = splp_pkg::SPLP_CAPTURE;
        end
      end
      splp_pkg::SPLP_CAPTURE:
      begin
        bc1_d = pins_s[0];
        bc2_d = pins_s[1];
        lp_d = pins_s[4];
        fd_d = pins_s[6:5];
        cnt_d = '0;
        state_d = splp_pkg::SPLP_CONFIG;
      end
      // Configuration window; register may be written.
      splp_pkg::SPLP_CONFIG:
      begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == splp_pkg::CFG_CNT_W'(splp_pkg::CFG_CYCLES - 1))
        begin
          state_d = splp_pkg::SPLP_RUN;
        end
      end
      splp_pkg::SPLP_RUN:
      begin
        if (dyn_en)
        begin
          lp_d = pins_s[4];
        end
      end
      default:
      begin
        state_d = splp_pkg::SPLP_WAIT;
      end
    endcase
    if (reg_wr && reg_addr == splp_pkg::DYN_PWR_ADDR)
    begin
      dyn_d = reg_wdata;
    end
  end

  // Registers; reset returns everything to defaults so straps recapture.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= splp_pkg::SPLP_WAIT;
      cnt_q <= '0;
      bc1_q <= 1'b0;
      bc2_q <= 1'b0;
      lp_q <= 1'b0;
      fd_q <= 2'h0;
      dyn_q <= splp_pkg::DYN_PWR_RESET;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bc1_q <= bc1_d;
      bc2_q <= bc2_d;
      lp_q <= lp_d;
      fd_q <= fd_d;
      dyn_q <= dyn_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive and output registers
  // ----------------------------------------------------------------
  // Next values of outputs.
  logic p1o_d, p1e_d, p2o_d, p2e_d, oc1_d, oc2_d;
  logic bc1o_d, bc2o_d, lpo_d, done_d;
  logic [1:0] fdo_d;
  logic [7:0] rd_d;
  logic p1o_q, p1e_q, p2o_q, p2e_q, oc1_q, oc2_q;
  logic bc1o_q, bc2o_q, lpo_q, done_q;
  logic [1:0] fdo_q;
  logic [7:0] rd_q;
  // Recent drive enables per shared pin; all zero once the pin has settled released.
  logic [splp_pkg::SENSE_SETTLE-1:0] drv1_q, drv1_d, drv2_q, drv2_d;
  // Straps captured; pins may be driven.
  logic drive_ok;

  assign drive_ok = (state_q == splp_pkg::SPLP_CONFIG) || (state_q == splp_pkg::SPLP_RUN);

  // Computes pin drive, over-current and status.
  always_comb
  begin
    // The synchroniser lags the pin, so a freshly released pin reads stale low.
    drv1_d = {drv1_q[splp_pkg::SENSE_SETTLE-2:0], p1e_q};
    drv2_d = {drv2_q[splp_pkg::SENSE_SETTLE-2:0], p2e_q};
    p1e_d = drive_ok;
    p2e_d = drive_ok;
    p1o_d = drive_ok && port1_power_req;
    p2o_d = drive_ok && port2_power_req;
    if (port1_combined_control)
    begin
      // Open drain: drive low only, release high to let sensing see the pin.
      p1e_d = drive_ok && !port1_power_req;
      // Sensing waits until the released level has crossed the synchroniser.
      oc1_d = drive_ok && port1_power_req && (drv1_q == '0) && !pins_s[0];
    end
    else
    begin
      oc1_d = !pins_s[2];
    end
    if (port2_combined_control)
    begin
      p2e_d = drive_ok && !port2_power_req;
      oc2_d = drive_ok && port2_power_req && (drv2_q == '0) && !pins_s[1];
    end
    else
    begin
      oc2_d = !pins_s[3];
    end
    bc1o_d = bc1_q;
    bc2o_d = bc2_q;
    lpo_d = lp_q;
    fdo_d = lp_q ? fixed_device_cfg : fd_q;
    done_d = (state_q == splp_pkg::SPLP_RUN);
    rd_d = (reg_rd && reg_addr == splp_pkg::DYN_PWR_ADDR) ? dyn_q : 8'h00;
  end

  // Output registers.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      p1o_q <= 1'b0;
      p1e_q <= 1'b0;
      p2o_q <= 1'b0;
      p2e_q <= 1'b0;
      oc1_q <= 1'b0;
      oc2_q <= 1'b0;
      bc1o_q <= 1'b0;
      bc2o_q <= 1'b0;
      lpo_q <= 1'b0;
      done_q <= 1'b0;
      fdo_q <= 2'h0;
      rd_q <= 8'h00;
      drv1_q <= '1;
      drv2_q <= '1;
    end
    else
    begin
      p1o_q <= p1o_d;
      p1e_q <= p1e_d;
      p2o_q <= p2o_d;
      p2e_q <= p2e_d;
      oc1_q <= oc1_d;
      oc2_q <= oc2_d;
      bc1o_q <= bc1o_d;
      bc2o_q <= bc2o_d;
      lpo_q <= lpo_d;
      done_q <= done_d;
      fdo_q <= fdo_d;
      rd_q <= rd_d;
      drv1_q <= drv1_d;
      drv2_q <= drv2_d;
    end
  end

  assign port1_ctl_out = p1o_q;
  assign port1_ctl_oe = p1e_q;
  assign port2_ctl_out = p2o_q;
  assign port2_ctl_oe = p2e_q;
  assign port1_overcurrent = oc1_q;
  assign port2_overcurrent = oc2_q;
  assign port1_charging_en = bc1o_q;
  assign port2_charging_en = bc2o_q;
  assign self_powered = lpo_q;
  assign fixed_device = fdo_q;
  assign config_done = done_q;
  assign reg_rdata = rd_q;
endmodule
`default_nettype wire

/* File: rtl/splp_pkg.sv */
// Purpose: Shared constants for the strap latch and port power pin block.
// Assumes: One clock domain, mclk at 200 MHz.
// Notes: Register offsets and reset values are named here once.
package splp_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // Address of the dynamic power control register.
  localparam logic [15:0] DYN_PWR_ADDR = 16'h4134;
  // Reset value of the dynamic power control register.
  localparam logic [7:0] DYN_PWR_RESET = 8'hc1;
  // Value that enables dynamic local-power switching.
  localparam logic [7:0] DYN_PWR_ENABLE = 8'h41;
  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  // Cycles spent in the configuration state before it completes.
  localparam int CFG_CYCLES = 4;
  // Width of the configuration counter.
  localparam int CFG_CNT_W = 3;
  // Cycles a shared pin must stay released before its synchronised level is trusted.
  localparam int SENSE_SETTLE = 4;
  // Configuration states.
  typedef enum logic [1:0] {
    SPLP_WAIT,
    SPLP_CAPTURE,
    SPLP_CONFIG,
    SPLP_RUN
  } splp_state_t;
endpackage

/* File: rtl/splp_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Input is asynchronous to mclk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module splp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  // Stage registers.
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  // Filtered value, next value.
  logic [W-1:0] out_q;
  logic [W-1:0] out_d;

  // ----------------------------------------------------------------
  // Filter
  // ----------------------------------------------------------------
  // A change counts once stages two and three agree.
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
    end
  end

  // Registers the stages and the filtered value.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      out_q <= INIT;
    end
    else
    begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;
endmodule
`default_nettype wire

/* File: tb/splp_pin_model.sv */
// Purpose: Board side of one shared pin: strap resistor and power switch.
// Assumes: The switch flags over-current by pulling the released pin low.
// Notes: A released pin never keeps the device's last driven level.
`timescale 1ns/1ps
`default_nettype none
module splp_pin_model (
  input wire logic oe,
  input wire logic out,
  input wire logic strap,
  input wire logic fault,
  output logic pin
);
  assign pin = oe ? out : (fault ? 1'b0 : strap);
endmodule
`default_nettype wire

/* File: tb/splp_top_assertions.sv */
// Purpose: Checks pin drive, strap hold and the register port.
// Assumes: One clock mclk and async active-low reset_n.
// Notes: Keeps its own copy of the register from observed writes.
`timescale 1ns/1ps
`default_nettype none
module splp_top_assertions (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic port1_ctl_out,
  input wire logic port1_ctl_oe,
  input wire logic port2_ctl_out,
  input wire logic port2_ctl_oe,
  input wire logic port1_combined_control,
  input wire logic port2_combined_control,
  input wire logic port1_power_req,
  input wire logic port2_power_req,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic port1_charging_en,
  input wire logic port2_charging_en,
  input wire logic self_powered,
  input wire logic config_done
);
  // Cycles since reset release, saturating, and the register copy.
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] dyn_q, dyn_d;
  always_comb
  begin
    cnt_d = (cnt_q == 3'h7) ? cnt_q : cnt_q + 3'h1;
    dyn_d = (reg_wr && reg_addr == splp_pkg::DYN_PWR_ADDR) ? reg_wdata : dyn_q;
  end
  // Registers the helper state.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q <= 3'h0;
      dyn_q <= splp_pkg::DYN_PWR_RESET;
    end
    else
    begin
      cnt_q <= cnt_d;
      dyn_q <= dyn_d;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Direct mode drives the request; combined mode releases the pin for power.
  property p_drive(logic oe, logic out, logic cm, logic rq);
    $past(config_done) && $stable(cm) |->
      (cm ? (oe == !$past(rq) && !(oe && out)) : (oe && out == $past(rq)));
  endproperty
  a_pins_early_off: assert property (cnt_q < 3'h4 |-> !port1_ctl_oe && !port2_ctl_oe)
    else $error("shared pin driven before strap capture");
  a_port1_drive: assert property (
    p_drive(port1_ctl_oe, port1_ctl_out, port1_combined_control, port1_power_req))
    else $error("port 1 pin drive wrong");
  a_port2_drive: assert property (
    p_drive(port2_ctl_oe, port2_ctl_out, port2_combined_control, port2_power_req))
    else $error("port 2 pin drive wrong");
  a_charge_hold: assert property (config_done && $past(config_done) |->
    $stable({port1_charging_en, port2_charging_en}))
    else $error("charging strap changed after capture");
  // The live copy reaches the output two registers after the enable is seen.
  a_self_hold: assert property (config_done && $past(config_done) &&
    $past(dyn_q, 2) != splp_pkg::DYN_PWR_ENABLE |-> $stable(self_powered))
    else $error("self power changed while static");
  a_reg_read: assert property (reg_rd && reg_addr == splp_pkg::DYN_PWR_ADDR |=>
    reg_rdata == $past(dyn_q))
    else $error("register read wrong");
  a_unmapped_zero: assert property (reg_rd && reg_addr != splp_pkg::DYN_PWR_ADDR |=>
    reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data without read");
  c_config: cover property ($rose(config_done));
  c_combined: cover property (port2_combined_control && port2_power_req && !port2_ctl_oe);
  c_dynamic: cover property (reg_wr && reg_wdata == splp_pkg::DYN_PWR_ENABLE);
endmodule
bind splp_top splp_top_assertions u_chk (.mclk, .reset_n, .port1_ctl_out, .port1_ctl_oe,
  .port2_ctl_out, .port2_ctl_oe, .port1_combined_control, .port2_combined_control,
  .port1_power_req, .port2_power_req, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .port1_charging_en, .port2_charging_en, .self_powered, .config_done);
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: Directed test of straps, shared pins and the register port.
// Assumes: Inputs change at the falling edge of mclk.
// Notes: Two reset passes capture both strap levels.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk, reset_n, port1_combined_control, port2_combined_control;
  logic port1_overcurrent_low, port2_overcurrent_low, self_power_detect;
  logic [1:0] fixed_device_straps, fixed_device_cfg, fixed_device;
  logic port1_power_req, port2_power_req, reg_wr, reg_rd;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic port1_ctl_out, port1_ctl_oe, port2_ctl_out, port2_ctl_oe, pin1, pin2;
  logic port1_charging_en, port2_charging_en, self_powered, config_done;
  logic port1_overcurrent, port2_overcurrent, strap, fault;
  int err_count = 0;
  int compares = 0;
  splp_top u_dut (.mclk, .reset_n, .port1_ctl_in(pin1), .port1_ctl_out, .port1_ctl_oe,
    .port2_ctl_in(pin2), .port2_ctl_out, .port2_ctl_oe, .port1_combined_control,
    .port2_combined_control, .port1_overcurrent_low, .port2_overcurrent_low,
    .self_power_detect, .fixed_device_straps, .fixed_device_cfg, .port1_power_req,
    .port2_power_req, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .port1_charging_en, .port2_charging_en, .self_powered, .fixed_device,
    .port1_overcurrent, .port2_overcurrent, .config_done);
  splp_pin_model u_pin1 (.oe(port1_ctl_oe), .out(port1_ctl_out), .strap, .fault, .pin(pin1));
  splp_pin_model u_pin2 (.oe(port2_ctl_oe), .out(port2_ctl_out), .strap, .fault, .pin(pin2));
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic conclude();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic reg_write(input logic [15:0] a, input logic [7:0] v);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge mclk);
    reg_wr = 1'b0;
    @(negedge mclk);
  endtask
  task automatic reg_read(input logic [15:0] a, output logic [7:0] v);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    v = reg_rdata;
    reg_rd = 1'b0;
    @(negedge mclk);
  endtask
  // Resets with the given strap level and waits for configuration to end.
  task automatic start(input logic v);
    strap = v;
    self_power_detect = v;
    reset_n = 1'b0;
    repeat (3) @(negedge mclk);
    reset_n = 1'b1;
    for (int n = 0; n < 40 && config_done !== 1'b1; n++) @(negedge mclk);
    if (config_done !== 1'b1)
    begin
      err_count++;
      conclude();
    end
  endtask
  initial
  begin
    {reset_n, reg_wr, reg_rd, port1_combined_control, port2_combined_control} = 5'h00;
    {port1_power_req, port2_power_req, strap, fault, self_power_detect} = 5'h00;
    {port1_overcurrent_low, port2_overcurrent_low} = 2'h3;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    fixed_device_straps = 2'h1;
    fixed_device_cfg = 2'h2;
    for (int v = 0; v < 2; v++)
    begin
      start(v[0]);
      check(8'(port1_charging_en), 8'(v));
      check(8'(port2_charging_en), 8'(v));
      check(8'(self_powered), 8'(v));
      check(8'(fixed_device), v ? 8'h02 : 8'h01);
    end
    for (int m = 0; m < 4; m++)
    begin
      {port1_combined_control, port2_combined_control} = {2{m[1]}};
      {port1_power_req, port2_power_req} = {2{m[0]}};
      repeat (3) @(negedge mclk);
      check(8'(pin1), 8'(m[0]));
      check(8'(pin2), 8'(m[0]));
      check(8'({port1_overcurrent, port2_overcurrent}), 8'h00);
    end
    fault = 1'b1;
    repeat (8) @(negedge mclk);
    check(8'({port1_overcurrent, port2_overcurrent}), 8'h03);
    fault = 1'b0;
    repeat (8) @(negedge mclk);
    check(8'({port1_overcurrent, port2_overcurrent}), 8'h00);
    // Direct mode senses the dedicated over-current inputs instead of the pin.
    {port1_combined_control, port2_combined_control} = 2'h0;
    {port1_overcurrent_low, port2_overcurrent_low} = 2'h0;
    repeat (8) @(negedge mclk);
    check(8'({port1_overcurrent, port2_overcurrent}), 8'h03);
    {port1_overcurrent_low, port2_overcurrent_low} = 2'h3;
    repeat (8) @(negedge mclk);
    check(8'({port1_overcurrent, port2_overcurrent}), 8'h00);
    reg_read(splp_pkg::DYN_PWR_ADDR, d);
    check(d, 8'hc1);
    reg_read(16'h4135, d);
    check(d, 8'h00);
    reg_write(splp_pkg::DYN_PWR_ADDR, 8'h41);
    self_power_detect = 1'b0;
    repeat (8) @(negedge mclk);
    check(8'(self_powered), 8'h00);
    reg_write(splp_pkg::DYN_PWR_ADDR, 8'hc1);
    self_power_detect = 1'b1;
    repeat (8) @(negedge mclk);
    check(8'(self_powered), 8'h00);
    conclude();
  end
endmodule
`default_nettype wire
